/* rtl/cbseq_top.sv */
`timescale 1ns/10ps
// How it works
// - Dead cycles drive FFFF, read, data ignored
// - Extended jump: opcode, target high, target low
// - Extended byte read takes four cycles
// - Extended accumulator store writes in cycle four
// - Extended 16-bit load reads high then low
// - Extended 16-bit store writes high then low
// - Read-modify-write: read, dead, write same address
// - Memory test replaces final write with dead
// - 16-bit arithmetic reads two bytes, trailing dead
// - Extended call fetches target, pushes return low first
// - Indexed: offset, dead, operand at index+offset
// - Indexed 16-bit load/store at offset and offset+1
// - Indexed arithmetic and call take six cycles
// - Inherent cycle two reads opcode address plus one
// - Stack adjust reads previous stack pointer third
// - Pushes write accumulator or index low, high
// - Accumulator pull: dummy read, then SP+1
// - Index pull and return read SP+1, SP+2
// - Wait stacks seven bytes descending from SP
// - Interrupt return reads seven bytes ascending
// - Software trap stacks same seven bytes first
// - Software trap reads vector at FFFA, FFFB
// - Internal reads driven out only with the exposure strap set
module cbseq_top (
  // Clock and reset
  input  wire logic                        mclk_i,
  input  wire logic                        reset_n_i,
  // Core register values to stack, write or use as bases
  input  wire logic [15:0]                 index_i,
  input  wire logic [7:0]                  acc_a_i,
  input  wire logic [7:0]                  acc_b_i,
  input  wire logic [7:0]                  ccr_i,
  input  wire logic [7:0]                  store_hi_i,
  input  wire logic [7:0]                  store_lo_i,
  input  wire logic [7:0]                  rmw_data_i,
  // Mode strap: internal reads visible externally
  input  wire logic                        expose_int_i,
  input  wire logic                        internal_sel_i,
  // External bus
  output logic [cbseq_pkg::ADDR_W-1:0]     addr_o,
  output logic                             rw_o,
  output logic [cbseq_pkg::DATA_W-1:0]     data_out_o,
  output logic                             data_oe_o,
  input  wire logic [cbseq_pkg::DATA_W-1:0] data_in_i,
  // Status to the core
  output cbseq_pkg::cbseq_kind_type        kind_o,
  output logic [3:0]                       cycle_o,
  output logic                             last_cycle_o,
  output logic                             bad_opcode_o,
  output logic [15:0]                      pc_o,
  output logic [15:0]                      sp_o,
  output logic [7:0]                       read_data_o
);
  import cbseq_pkg::*;

  // Sequencer state
  logic [3:0]        cyc_q;        // 1 = opcode fetch
  logic [7:0]        op_q;
  logic [15:0]       pc_q;         // opcode address of current instruction
  logic [15:0]       sp_q;
  logic [15:0]       ea_q;         // operand address being built
  logic [15:0]       ret_q;        // address of the next instruction
  logic [7:0]        rd_q;
  logic [7:0]        dsync1_q;
  logic [7:0]        dsync2_q;
  logic              exp1_q;
  logic              exp2_q;
  logic              isel1_q;
  logic              isel2_q;
  cbseq_class_type   cls;
  logic              idx;
  logic [3:0]        len;
  logic              known;
  logic              last;
  logic [15:0]       addr_d;
  logic              rw_d;
  logic [7:0]        wdata_d;
  cbseq_kind_type    kind_d;

  // During cycle 1 the opcode arrives on the bus; decode it live then
  logic [7:0] op_now;
  assign op_now = (cyc_q == ONE4) ? data_in_i : op_q;

  cbseq_decode u_decode (
    .opcode_i  (op_now),
    .class_o   (cls),
    .indexed_o (idx),
    .length_o  (len),
    .known_o   (known)
  );

  assign last = (cyc_q == len);

  // Strap and select come from pins: two stages before use
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      exp1_q  <= 1'b0;
      exp2_q  <= 1'b0;
      isel1_q <= 1'b0;
      isel2_q <= 1'b0;
    end else begin
      exp1_q  <= expose_int_i;
      exp2_q  <= exp1_q;
      isel1_q <= internal_sel_i;
      isel2_q <= isel1_q;
    end
  end

  // Read data is sampled the same cycle, then passes a second stage before it is echoed
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dsync1_q <= 8'h00;
      dsync2_q <= 8'h00;
    end else begin
      dsync1_q <= data_in_i;
      dsync2_q <= dsync1_q;
    end
  end

  // Bus cycle table: address, read/write level and data meaning per step
  always_comb begin
    addr_d  = DEAD_ADDR;
    rw_d    = RW_READ;
    wdata_d = 8'h00;
    kind_d  = CBSEQ_DK_IGNORE;
    if (cyc_q == ONE4) begin
      addr_d = pc_q;
      kind_d = CBSEQ_DK_OPCODE;
    end else if (cyc_q == 4'h2) begin
      addr_d = pc_q + ONE16;
      kind_d = (cls inside {CBSEQ_OP_NOP2, CBSEQ_OP_INH3_DEAD, CBSEQ_OP_STACK_ADJ, CBSEQ_OP_PUSH_ACC,
                            CBSEQ_OP_PULL_ACC, CBSEQ_OP_WAIT}) ? CBSEQ_DK_NEXT_OP :
               (cls inside {CBSEQ_OP_PUSH_INDEX, CBSEQ_OP_PULL_INDEX, CBSEQ_OP_RETURN,
                            CBSEQ_OP_MUL, CBSEQ_OP_IRET, CBSEQ_OP_TRAP}) ? CBSEQ_DK_IGNORE :
               CBSEQ_DK_PROG;
    end else begin
      unique case (cls)
        CBSEQ_OP_NOP2, CBSEQ_OP_INH3_DEAD, CBSEQ_OP_MUL: begin
          addr_d = DEAD_ADDR;
        end
        CBSEQ_OP_STACK_ADJ: begin
          addr_d = sp_q;
        end
        CBSEQ_OP_PUSH_ACC, CBSEQ_OP_PUSH_INDEX: begin
          addr_d  = sp_q - {12'h000, cyc_q - 4'h3};
          rw_d    = RW_WRITE;
          kind_d  = CBSEQ_DK_WRITE;
          wdata_d = (cls == CBSEQ_OP_PUSH_ACC) ? (op_q[0] ? acc_b_i : acc_a_i) :
                    ((cyc_q == 4'h3) ? index_i[7:0] : index_i[15:8]);
        end
        CBSEQ_OP_PULL_ACC, CBSEQ_OP_PULL_INDEX, CBSEQ_OP_RETURN, CBSEQ_OP_IRET: begin
          addr_d = sp_q + {12'h000, cyc_q - 4'h3};
          kind_d = (cyc_q == 4'h3) ? CBSEQ_DK_IGNORE : CBSEQ_DK_STACK_IN;
        end
        CBSEQ_OP_WAIT, CBSEQ_OP_TRAP: begin
          if (cyc_q <= 4'h9) begin
            addr_d = sp_q - {12'h000, cyc_q - 4'h3};
            rw_d   = RW_WRITE;
            kind_d = CBSEQ_DK_WRITE;
            unique case (cyc_q)
              4'h3:    wdata_d = ret_q[7:0];
              4'h4:    wdata_d = ret_q[15:8];
              4'h5:    wdata_d = index_i[7:0];
              4'h6:    wdata_d = index_i[15:8];
              4'h7:    wdata_d = acc_a_i;
              4'h8:    wdata_d = acc_b_i;
              default: wdata_d = ccr_i;
            endcase
          end else if (cyc_q == 4'hA) begin
            addr_d = sp_q - 16'h0007;
          end else begin
            addr_d = (cyc_q == 4'hB) ? SWI_VEC_HI : SWI_VEC_LO;
            kind_d = CBSEQ_DK_VECTOR;
          end
        end
        default: begin
          // Memory reference: extended uses cycle 3 for address low, indexed a dead cycle
          if (cyc_q == 4'h3) begin
            addr_d = idx ? DEAD_ADDR : pc_q + 16'h0002;
            kind_d = idx ? CBSEQ_DK_IGNORE : CBSEQ_DK_PROG;
          end else if (cls == CBSEQ_OP_CALL) begin
            if (cyc_q == 4'h4) begin
              addr_d = ea_q;
              kind_d = CBSEQ_DK_NEXT_OP;
            end else begin
              addr_d  = sp_q - {12'h000, cyc_q - 4'h5};
              rw_d    = RW_WRITE;
              kind_d  = CBSEQ_DK_WRITE;
              wdata_d = (cyc_q == 4'h5) ? ret_q[7:0] : ret_q[15:8];
            end
          end else if (cyc_q == 4'h6) begin
            addr_d = ea_q;
            if (cls == CBSEQ_OP_RMW) begin
              rw_d    = RW_WRITE;
              kind_d  = CBSEQ_DK_WRITE;
              wdata_d = rmw_data_i;
            end else begin
              addr_d = DEAD_ADDR;
            end
          end else if (cyc_q == 4'h5 && cls inside {CBSEQ_OP_RMW, CBSEQ_OP_TEST}) begin
            addr_d = DEAD_ADDR;
          end else begin
            addr_d = ea_q + ((cyc_q == 4'h5) ? ONE16 : 16'h0000);
            kind_d = CBSEQ_DK_OPERAND;
            if (cls inside {CBSEQ_OP_STORE8, CBSEQ_OP_STORE16}) begin
              rw_d    = RW_WRITE;
              kind_d  = CBSEQ_DK_WRITE;
              wdata_d = (cyc_q == 4'h4) ? store_hi_i : store_lo_i;
            end
          end
        end
      endcase
    end
  end

  // Step counter, opcode latch and program counter
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cyc_q <= ONE4;
      op_q  <= 8'h00;
      pc_q  <= RESET_PC;
    end else if (!known) begin
      // An unknown opcode costs one fetch; carry on at the byte after it
      cyc_q <= ONE4;
      pc_q  <= pc_q + ONE16;
    end else if (last) begin
      // A target byte read in the closing step is taken off the bus, not from its register copy
      cyc_q <= ONE4;
      pc_q  <= (cls == CBSEQ_OP_TRAP || (cls == CBSEQ_OP_JUMP && !idx)) ? {ea_q[15:8], data_in_i} :
               (cls inside {CBSEQ_OP_JUMP, CBSEQ_OP_CALL}) ? ea_q :
               (cls inside {CBSEQ_OP_RETURN, CBSEQ_OP_IRET}) ? {ret_q[15:8], data_in_i} : ret_q;
    end else begin
      cyc_q <= cyc_q + ONE4;
      if (cyc_q == ONE4) begin
        op_q <= data_in_i;
      end
    end
  end

  // Effective address and return address
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ea_q  <= 16'h0000;
      ret_q <= 16'h0000;
    end else begin
      if (cyc_q == ONE4) begin
        ret_q <= pc_q + ONE16;
      end else if (cyc_q == 4'h2 && !(cls inside {CBSEQ_OP_NOP2, CBSEQ_OP_INH3_DEAD, CBSEQ_OP_STACK_ADJ,
                   CBSEQ_OP_PUSH_ACC, CBSEQ_OP_PULL_ACC, CBSEQ_OP_WAIT, CBSEQ_OP_PUSH_INDEX,
                   CBSEQ_OP_PULL_INDEX, CBSEQ_OP_RETURN, CBSEQ_OP_MUL, CBSEQ_OP_IRET, CBSEQ_OP_TRAP})) begin
        ret_q <= pc_q + (idx ? 16'h0002 : 16'h0003);
        ea_q  <= idx ? index_i + {8'h00, data_in_i} : {data_in_i, 8'h00};
      end else if (cyc_q == 4'h3 && !idx && kind_d == CBSEQ_DK_PROG) begin
        ea_q <= {ea_q[15:8], data_in_i};
      end else if (cls inside {CBSEQ_OP_RETURN, CBSEQ_OP_IRET} && kind_d == CBSEQ_DK_STACK_IN) begin
        if (cyc_q == len - ONE4) ret_q[15:8] <= data_in_i;
        if (cyc_q == len) ret_q[7:0] <= data_in_i;
      end else if (cls == CBSEQ_OP_TRAP && cyc_q == 4'hB) begin
        ea_q <= {data_in_i, 8'h00};
      end
    end
  end

  // Stack pointer tracking per instruction
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sp_q <= RESET_SP;
    end else if (last) begin
      unique case (cls)
        CBSEQ_OP_STACK_ADJ:  sp_q <= op_q[0] ? sp_q + ONE16 : sp_q - ONE16;
        CBSEQ_OP_PUSH_ACC:   sp_q <= sp_q - ONE16;
        CBSEQ_OP_PUSH_INDEX: sp_q <= sp_q - 16'h0002;
        CBSEQ_OP_CALL:       sp_q <= sp_q - 16'h0002;
        CBSEQ_OP_PULL_ACC:   sp_q <= sp_q + ONE16;
        CBSEQ_OP_PULL_INDEX: sp_q <= sp_q + 16'h0002;
        CBSEQ_OP_RETURN:     sp_q <= sp_q + 16'h0002;
        CBSEQ_OP_IRET:       sp_q <= sp_q + 16'h0007;
        CBSEQ_OP_WAIT:       sp_q <= sp_q - 16'h0007;
        CBSEQ_OP_TRAP:       sp_q <= sp_q - 16'h0007;
        CBSEQ_OP_INH3_DEAD:  sp_q <= (op_q == 8'h35) ? index_i - ONE16 : sp_q;
        default:             sp_q <= sp_q;
      endcase
    end
  end

  // Registered copy of returned read data for the core
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_q <= 8'h00;
    end else if (rw_d == RW_READ && kind_d != CBSEQ_DK_IGNORE) begin
      rd_q <= data_in_i;
    end
  end

  // Bus outputs. Address and rw are combinational so the access lands in its own cycle;
  // an internal read is echoed only when the exposure strap is set.
  assign addr_o       = addr_d;
  assign rw_o         = rw_d;
  assign kind_o       = kind_d;
  assign cycle_o      = cyc_q;
  assign last_cycle_o = last;
  assign bad_opcode_o = !known;
  assign pc_o         = pc_q;
  assign sp_o         = sp_q;
  assign read_data_o  = rd_q;
  assign data_out_o   = (rw_d == RW_WRITE) ? wdata_d : dsync2_q;
  assign data_oe_o    = (rw_d == RW_WRITE) || (rw_d == RW_READ && isel2_q && exp2_q);

endmodule

/* pkg/cbseq_pkg.sv */
package cbseq_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  // Fixed addresses
  localparam logic [15:0] DEAD_ADDR      = 16'hFFFF;
  localparam logic [15:0] SWI_VEC_HI     = 16'hFFFA;
  localparam logic [15:0] SWI_VEC_LO     = 16'hFFFB;
  localparam logic [15:0] RESET_PC       = 16'h0000;
  localparam logic [15:0] RESET_SP       = 16'h00FF;
  localparam logic [15:0] ONE16          = 16'h0001;
  localparam logic [3:0]  ONE4           = 4'h1;
  localparam logic [3:0]  MUL_DEAD_FIRST = 4'h3;
  localparam logic [3:0]  MUL_DEAD_LAST  = 4'hA;

  // Read/write line levels
  localparam logic RW_READ  = 1'b1;
  localparam logic RW_WRITE = 1'b0;

  // Instruction classes decoded from the opcode
  typedef enum logic [4:0] {
    CBSEQ_OP_NOP2,
    CBSEQ_OP_INH3_DEAD,       // index_increment_op, index_decrement_op, index_to_stack_op
    CBSEQ_OP_STACK_ADJ,       // stack_increment_op and its decrement twin
    CBSEQ_OP_PUSH_ACC,        // push_acc_a_op, push_acc_b_op
    CBSEQ_OP_PUSH_INDEX,      // push_index_op
    CBSEQ_OP_PULL_ACC,        // pull_acc_a_op, pull_acc_b_op
    CBSEQ_OP_PULL_INDEX,      // pull_index_op
    CBSEQ_OP_RETURN,          // subroutine return
    CBSEQ_OP_WAIT,            // wait_interrupt_op
    CBSEQ_OP_MUL,             // multiply_op
    CBSEQ_OP_IRET,            // interrupt_return_op
    CBSEQ_OP_TRAP,            // software_trap_op
    CBSEQ_OP_JUMP,            // jump_op
    CBSEQ_OP_READ8,
    CBSEQ_OP_STORE8,          // accumulator_store_op
    CBSEQ_OP_LOAD16,
    CBSEQ_OP_STORE16,
    CBSEQ_OP_RMW,
    CBSEQ_OP_TEST,            // memory_test_op
    CBSEQ_OP_ARITH16,         // compare_index_op, subtract_double_op, add_double_op
    CBSEQ_OP_CALL             // subroutine_call_op
  } cbseq_class_type;

  // Meaning of the data bus word in the current cycle
  typedef enum logic [3:0] {
    CBSEQ_DK_OPCODE,
    CBSEQ_DK_PROG,
    CBSEQ_DK_IGNORE,
    CBSEQ_DK_OPERAND,
    CBSEQ_DK_WRITE,
    CBSEQ_DK_STACK_IN,
    CBSEQ_DK_VECTOR,
    CBSEQ_DK_NEXT_OP
  } cbseq_kind_type;

endpackage

/* rtl/cbseq_decode.sv */
`timescale 1ns/10ps
module cbseq_decode (
  // Opcode in
  input  wire logic [7:0]                opcode_i,
  // Decoded class
  output cbseq_pkg::cbseq_class_type     class_o,
  output logic                           indexed_o,
  output logic [3:0]                     length_o,
  output logic                           known_o
);
  import cbseq_pkg::*;

  // Group by low nibble for extended (7x/Bx/Fx) and indexed (6x/Ax/Ex) forms
  always_comb begin
    class_o   = CBSEQ_OP_NOP2;
    indexed_o = 1'b0;
    length_o  = 4'h2;
    known_o   = 1'b1;
    unique case (opcode_i)
      8'h08, 8'h09, 8'h35: begin class_o = CBSEQ_OP_INH3_DEAD;  length_o = 4'h3; end
      8'h31, 8'h34:        begin class_o = CBSEQ_OP_STACK_ADJ;  length_o = 4'h3; end
      8'h36, 8'h37:        begin class_o = CBSEQ_OP_PUSH_ACC;   length_o = 4'h3; end
      8'h3C:               begin class_o = CBSEQ_OP_PUSH_INDEX; length_o = 4'h4; end
      8'h32, 8'h33:        begin class_o = CBSEQ_OP_PULL_ACC;   length_o = 4'h4; end
      8'h38:               begin class_o = CBSEQ_OP_PULL_INDEX; length_o = 4'h5; end
      8'h39:               begin class_o = CBSEQ_OP_RETURN;     length_o = 4'h5; end
      8'h3E:               begin class_o = CBSEQ_OP_WAIT;       length_o = 4'h9; end
      8'h3D:               begin class_o = CBSEQ_OP_MUL;        length_o = 4'hA; end
      8'h3B:               begin class_o = CBSEQ_OP_IRET;       length_o = 4'hA; end
      8'h3F:               begin class_o = CBSEQ_OP_TRAP;       length_o = 4'hC; end
      8'h6E, 8'h7E: begin class_o = CBSEQ_OP_JUMP; length_o = 4'h3; indexed_o = ~opcode_i[4]; end
      8'h6D, 8'h7D: begin class_o = CBSEQ_OP_TEST; length_o = 4'h6; indexed_o = ~opcode_i[4]; end
      8'h60, 8'h63, 8'h64, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6A, 8'h6C, 8'h6F,
      8'h70, 8'h73, 8'h74, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7A, 8'h7C, 8'h7F: begin
        class_o = CBSEQ_OP_RMW; length_o = 4'h6; indexed_o = ~opcode_i[4];
      end
      8'hA3, 8'hAC, 8'hE3, 8'hB3, 8'hBC, 8'hF3: begin
        class_o = CBSEQ_OP_ARITH16; length_o = 4'h6; indexed_o = ~opcode_i[4];
      end
      8'hAD, 8'hBD: begin class_o = CBSEQ_OP_CALL; length_o = 4'h6; indexed_o = ~opcode_i[4]; end
      8'hA7, 8'hB7, 8'hE7, 8'hF7: begin
        class_o = CBSEQ_OP_STORE8; length_o = 4'h4; indexed_o = ~opcode_i[4];
      end
      8'hAE, 8'hBE, 8'hEE, 8'hFE, 8'hEC, 8'hFC: begin
        class_o = CBSEQ_OP_LOAD16; length_o = 4'h5; indexed_o = ~opcode_i[4];
      end
      8'hAF, 8'hBF, 8'hEF, 8'hFF, 8'hED, 8'hFD: begin
        class_o = CBSEQ_OP_STORE16; length_o = 4'h5; indexed_o = ~opcode_i[4];
      end
      8'hA0, 8'hA1, 8'hA2, 8'hA4, 8'hA5, 8'hA6, 8'hA8, 8'hA9, 8'hAA, 8'hAB,
      8'hB0, 8'hB1, 8'hB2, 8'hB4, 8'hB5, 8'hB6, 8'hB8, 8'hB9, 8'hBA, 8'hBB,
      8'hE0, 8'hE1, 8'hE2, 8'hE4, 8'hE5, 8'hE6, 8'hE8, 8'hE9, 8'hEA, 8'hEB,
      8'hF0, 8'hF1, 8'hF2, 8'hF4, 8'hF5, 8'hF6, 8'hF8, 8'hF9, 8'hFA, 8'hFB: begin
        class_o = CBSEQ_OP_READ8; length_o = 4'h4; indexed_o = ~opcode_i[4];
      end
      default: known_o = (opcode_i[7:4] == 4'h0) || (opcode_i[7:4] == 4'h1) ||
                         (opcode_i[7:4] == 4'h4) || (opcode_i[7:4] == 4'h5);
    endcase
  end

endmodule

/* tb/cbseq_assertions.sv */
`timescale 1ns/10ps
module cbseq_checker
  import cbseq_pkg::*;
(
  // Clock and reset
  input wire logic                            mclk_i,
  input wire logic                            reset_n_i,
  // Mode pin that lets internal reads show on the bus
  input wire logic                            expose_int_i,
  // Bus and status of the sequencer
  input wire logic [cbseq_pkg::ADDR_W-1:0]    addr_o,
  input wire logic                            rw_o,
  input wire logic                            data_oe_o,
  input wire cbseq_pkg::cbseq_kind_type       kind_o,
  input wire logic [3:0]                      cycle_o,
  input wire logic                            last_cycle_o,
  input wire logic                            bad_opcode_o
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  // Vector fetch closes the trap sequence
  sequence s_vector;
    addr_o == SWI_VEC_HI && rw_o == RW_READ ##1 addr_o == SWI_VEC_LO && rw_o == RW_READ && last_cycle_o;
  endsequence

  property p_ignore_read;
    kind_o == CBSEQ_DK_IGNORE |-> rw_o == RW_READ;
  endproperty
  property p_write_drive;
    rw_o == RW_WRITE |-> data_oe_o;
  endproperty
  property p_step_two;
    cycle_o == 4'h2 |-> addr_o == $past(addr_o) + ONE16;
  endproperty
  property p_last_fetch;
    last_cycle_o |=> cycle_o == ONE4;
  endproperty
  // Bad opcodes are excluded: their single step may not advance the count
  property p_cycle_adv;
    !last_cycle_o && !bad_opcode_o |=> cycle_o == $past(cycle_o) + ONE4;
  endproperty
  property p_fetch_read;
    cycle_o == ONE4 |-> rw_o == RW_READ;
  endproperty
  property p_trail_dead;
    last_cycle_o && cycle_o == 4'h6 && rw_o == RW_READ |-> addr_o == DEAD_ADDR;
  endproperty
  property p_vector;
    cycle_o == 4'hB |-> s_vector;
  endproperty
  // The pin passes two stages before it gates the echo
  property p_no_echo;
    rw_o == RW_READ && !$past(expose_int_i, 2) |-> !data_oe_o;
  endproperty

  a_ignore_read: assert property (p_ignore_read) else $error("ignored cycle is not a read");
  a_write_drive: assert property (p_write_drive) else $error("write without data drive");
  a_step_two: assert property (p_step_two) else $error("step two not at opcode address plus one");
  a_last_fetch: assert property (p_last_fetch) else $error("no fetch after last step");
  a_cycle_adv: assert property (p_cycle_adv) else $error("step count did not advance by one");
  a_fetch_read: assert property (p_fetch_read) else $error("opcode fetch is not a read");
  a_trail_dead: assert property (p_trail_dead) else $error("six step read end not at dead address");
  a_vector: assert property (p_vector) else $error("trap vector fetch wrong");
  a_no_echo: assert property (p_no_echo) else $error("internal read driven onto the bus");
endmodule

bind cbseq_top cbseq_checker u_chk (
  .mclk_i       (mclk_i),
  .reset_n_i    (reset_n_i),
  .expose_int_i (expose_int_i),
  .addr_o       (addr_o),
  .rw_o         (rw_o),
  .data_oe_o    (data_oe_o),
  .kind_o       (kind_o),
  .cycle_o      (cycle_o),
  .last_cycle_o (last_cycle_o),
  .bad_opcode_o (bad_opcode_o)
);

/* tb/cbseq_mem.sv */
`timescale 1ns/10ps
module cbseq_mem (
  // Clock
  input  wire logic        mclk_i,
  // Bus from the sequencer
  input  wire logic [15:0] addr_i,
  input  wire logic        rw_i,
  input  wire logic [7:0]  wdata_i,
  output logic [7:0]       rdata_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;

  // Read data in the same cycle; during writes the bus shows the inverse of the last read
  assign rdata_o = rw_i ? mem[addr_i] : ~last_q;

  // One transfer per clock, write taken at the edge ending the cycle
  always @(posedge mclk_i) begin
    if (rw_i) begin
      last_q <= mem[addr_i];
    end else begin
      mem[addr_i] <= wdata_i;
    end
  end

  // Start from a cleared memory so unmapped reads are known
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    last_q = 8'h00;
  end
endmodule

/* tb/cpu_bus_cycle_sequencer_tb.sv */
`timescale 1ns/10ps
module cpu_bus_cycle_sequencer_tb;
  import cbseq_pkg::*;
  logic mclk_i, reset_n_i, expose_int_i, internal_sel_i, rw_o, data_oe_o, last_cycle_o, bad_opcode_o;
  logic [15:0] index_i, addr_o, pc_o, sp_o;
  logic [7:0] acc_a_i, acc_b_i, ccr_i, store_hi_i, store_lo_i, rmw_data_i, data_out_o, data_in_i, read_data_o;
  logic [3:0] cycle_o;
  cbseq_kind_type kind_o;
  logic [7:0] prog [31] = '{8'hFE, 8'h12, 8'h34, 8'hFD, 8'h20, 8'h00, 8'h7D, 8'h20,
                            8'h10, 8'hA7, 8'h05, 8'hBD, 8'h30, 8'h00, 8'h3E, 8'hB6,
                            8'h20, 8'h00, 8'h3D, 8'h7C, 8'h20, 8'h00, 8'h3C, 8'h38,
                            8'h31, 8'h08, 8'h7E, 8'h00, 8'h1D, 8'h6E, 8'h10};
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;

  cbseq_top dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .index_i(index_i), .acc_a_i(acc_a_i),
    .acc_b_i(acc_b_i), .ccr_i(ccr_i), .store_hi_i(store_hi_i), .store_lo_i(store_lo_i),
    .rmw_data_i(rmw_data_i), .expose_int_i(expose_int_i), .internal_sel_i(internal_sel_i),
    .addr_o(addr_o), .rw_o(rw_o), .data_out_o(data_out_o), .data_oe_o(data_oe_o), .data_in_i(data_in_i),
    .kind_o(kind_o), .cycle_o(cycle_o), .last_cycle_o(last_cycle_o), .bad_opcode_o(bad_opcode_o),
    .pc_o(pc_o), .sp_o(sp_o), .read_data_o(read_data_o));
  cbseq_mem mem_u (.mclk_i(mclk_i), .addr_i(addr_o), .rw_i(rw_o), .wdata_i(data_out_o), .rdata_o(data_in_i));

  // Free running clock at 25 MHz
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Compares are made at the falling edge, where the step's outputs are settled
  task automatic check_bus(input logic [15:0] a, input logic rw);
    checked++;
    if (addr_o !== a || rw_o !== rw) begin
      n_fail++;
      $display("Error at %0t: bus %h/%b, expected %h/%b", $time, addr_o, rw_o, a, rw);
    end
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [15:0] a, input logic rw);
    @(negedge mclk_i);
    check_bus(a, rw);
  endtask
  // A run of reads at ascending addresses, or of writes at descending ones
  task automatic rd(input logic [15:0] a, input int n);
    for (int i = 0; i < n; i++) bus(a + 16'(i), RW_READ);
  endtask
  task automatic wd(input logic [15:0] a, input int n);
    for (int i = 0; i < n; i++) bus(a - 16'(i), RW_WRITE);
  endtask
  // Last step flag, then let the closing write land in memory
  task automatic finish_op;
    check_byte({7'h00, last_cycle_o}, 8'h01);
    @(posedge mclk_i);
    #1;
  endtask
  task automatic check_stack(input logic [15:0] top, input logic [15:0] ret);
    logic [7:0] exp [7];
    exp = '{ret[7:0], ret[15:8], index_i[7:0], index_i[15:8], acc_a_i, acc_b_i, ccr_i};
    for (int i = 0; i < 7; i++) check_byte(mem_u.mem[top - 16'(i)], exp[i]);
  endtask

  task automatic t_ext_load;
    rd(16'h0000, 3);
    rd(16'h1234, 2);
    finish_op();
  endtask
  task automatic t_ext_store;
    rd(16'h0003, 3);
    bus(16'h2000, RW_WRITE);
    bus(16'h2001, RW_WRITE);
    finish_op();
    check_byte(mem_u.mem[16'h2000], store_hi_i);
    check_byte(mem_u.mem[16'h2001], store_lo_i);
  endtask
  task automatic t_ext_test;
    rd(16'h0006, 3);
    rd(16'h2010, 1);
    repeat (2) bus(DEAD_ADDR, RW_READ);
    finish_op();
  endtask
  task automatic t_idx_store;
    rd(16'h0009, 2);
    rd(DEAD_ADDR, 1);
    bus(16'h2105, RW_WRITE);
    finish_op();
    check_byte(mem_u.mem[16'h2105], store_hi_i);
  endtask
  task automatic t_call;
    rd(16'h000B, 3);
    rd(16'h3000, 1);
    wd(RESET_SP, 2);
    finish_op();
    check_byte(mem_u.mem[16'h00FF], 8'h0E);
    check_byte(mem_u.mem[16'h00FE], 8'h00);
  endtask
  task automatic t_trap;
    rd(16'h3000, 2);
    wd(16'h00FD, 7);
    rd(16'h00F6, 1);
    rd(SWI_VEC_HI, 2);
    finish_op();
    check_stack(16'h00FD, 16'h3001);
  endtask
  task automatic t_iret;
    rd(16'h4000, 2);
    rd(16'h00F6, 8);
    finish_op();
  endtask
  task automatic t_ret;
    rd(16'h3001, 2);
    rd(16'h00FD, 3);
    finish_op();
  endtask
  task automatic t_wait;
    rd(16'h000E, 2);
    wd(RESET_SP, 7);
    finish_op();
    check_stack(RESET_SP, 16'h000F);
  endtask
  task automatic t_ext_read;
    rd(16'h000F, 3);
    rd(16'h2000, 1);
    finish_op();
    check_byte(read_data_o, store_hi_i);
  endtask
  task automatic t_mul;
    rd(16'h0012, 2);
    repeat (8) bus(DEAD_ADDR, RW_READ);
    finish_op();
  endtask
  task automatic t_ext_rmw;
    rd(16'h0013, 3);
    rd(16'h2000, 1);
    bus(DEAD_ADDR, RW_READ);
    bus(16'h2000, RW_WRITE);
    finish_op();
    check_byte(mem_u.mem[16'h2000], rmw_data_i);
  endtask
  task automatic t_push_pull;
    rd(16'h0016, 2);
    wd(16'h00F8, 2);
    finish_op();
    check_byte(mem_u.mem[16'h00F7], index_i[15:8]);
    rd(16'h0017, 2);
    rd(16'h00F6, 3);
    finish_op();
  endtask
  task automatic t_adjust;
    rd(16'h0018, 2);
    rd(16'h00F8, 1);
    finish_op();
    check_byte(sp_o[7:0], 8'hF9);
    rd(16'h0019, 2);
    bus(DEAD_ADDR, RW_READ);
    finish_op();
  endtask
  // Extended then indexed jump, landing on an opcode the decoder refuses
  task automatic t_jumps;
    rd(16'h001A, 3);
    finish_op();
    rd(16'h001D, 2);
    bus(DEAD_ADDR, RW_READ);
    finish_op();
    bus(16'h2110, RW_READ);
    check_byte({7'h00, bad_opcode_o}, 8'h01);
    bus(16'h2111, RW_READ);
  endtask

  // Main sequence: one program chained through all the instruction walks
  initial begin
    reset_n_i = 1'b0;
    index_i = 16'h2100;
    acc_a_i = 8'h11;
    acc_b_i = 8'h22;
    ccr_i = 8'hC0;
    store_hi_i = 8'h5A;
    store_lo_i = 8'hA5;
    rmw_data_i = 8'h3C;
    expose_int_i = 1'b0;
    internal_sel_i = 1'b1;
    #1;
    for (int i = 0; i < 31; i++) mem_u.mem[i] = prog[i];
    mem_u.mem[16'h2110] = 8'h87;
    mem_u.mem[16'h3000] = 8'h3F;
    mem_u.mem[16'h3001] = 8'h39;
    mem_u.mem[16'h4000] = 8'h3B;
    mem_u.mem[SWI_VEC_HI] = 8'h40;
    mem_u.mem[SWI_VEC_LO] = 8'h00;
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_ext_load();
    t_ext_store();
    t_ext_test();
    t_idx_store();
    t_call();
    t_trap();
    t_iret();
    t_ret();
    t_wait();
    t_ext_read();
    t_mul();
    t_ext_rmw();
    t_push_pull();
    t_adjust();
    t_jumps();
    give_verdict();
  end

  // The program needs just over a hundred cycles; a hang is cut off well beyond that
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 400) begin
      n_fail++;
      $display("Error at %0t: timeout", $time);
      give_verdict();
    end
  end
endmodule
